// ### verilog/cxd_pkg.sv
/*
  cxd_pkg: shared constants, types and helpers of the execution unit
  for the clear, call and decrement operations.
  assumes: included by name only, never imported.
*/
package cxd_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12; // apb address width
  localparam int DATA_W = 32; // apb data width
  localparam int BYTE_W = 8; // data path width
  localparam int PC_W = 13; // program counter width
  localparam int K_W = 11; // immediate call target width
  localparam int F_W = 7; // file address width
  localparam int OP_W = 4; // operation code width
  localparam int PCL_W = 5; // pc high latch width
  localparam int PCL_SEL_W = 2; // latch bits feeding pc top
  localparam int STK_DEPTH = 8; // return stack levels
  localparam int SP_W = 3; // stack pointer width
  localparam int ST_W = 2; // sequencer state width

  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFF_INSTR = 12'h000; // issue an operation
  localparam logic [ADDR_W-1:0] OFF_WREG = 12'h004; // working register
  localparam logic [ADDR_W-1:0] OFF_STATUS = 12'h008; // status flags
  localparam logic [ADDR_W-1:0] OFF_PC = 12'h00c; // program counter
  localparam logic [ADDR_W-1:0] OFF_PC_HIGH_LATCH = 12'h010; // pc high latch
  localparam logic [ADDR_W-1:0] OFF_TOS = 12'h014; // stack top, read only
  localparam logic [ADDR_W-1:0] OFF_STATE = 12'h018; // sequencer, read only
  localparam logic [ADDR_W-1:0] OFF_FILE_LO = 12'h200; // file word 0
  localparam logic [ADDR_W-1:0] OFF_FILE_HI = 12'h3fc; // file word 127

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int INSTR_OP_LSB = 0; // operation code
  localparam int INSTR_D_BIT = 4; // destination select
  localparam int INSTR_F_LSB = 5; // file address
  localparam int INSTR_K_LSB = 16; // call target
  localparam int ST_Z_BIT = 2; // zero flag
  localparam int ST_PD_BIT = 3; // power down flag
  localparam int ST_TO_BIT = 4; // timeout flag
  localparam int STATE_SP_LSB = 4; // stack pointer in state word
  localparam int PCL_SEL_LSB = 3; // latch bits 4:3
  localparam int FILE_IDX_LSB = 2; // word index in file window

  // ----------------------------------------------------------------
  // values
  // ----------------------------------------------------------------
  localparam logic [BYTE_W-1:0] ZERO8 = 8'h00; // cleared byte
  localparam logic [BYTE_W-1:0] ONE8 = 8'h01; // decrement step
  localparam logic [PC_W-1:0] PC_RST = 13'h0000; // pc after reset
  localparam logic [PC_W-1:0] PC_STEP = 13'h0001; // pc increment
  localparam logic [PCL_W-1:0] PC_HIGH_LATCH_RST = 5'h00; // latch after reset

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [OP_W-1:0] {
    nop_op = 4'h0,
    watchdog_clear_op = 4'h1,
    call_op = 4'h2,
    complement_file_op = 4'h3,
    clear_file_op = 4'h4,
    decrement_file_op = 4'h5,
    clear_work_reg_op = 4'h6,
    decrement_skip_zero_op = 4'h7
  } cxd_op_e;

  typedef enum logic [ST_W-1:0] {
    ST_IDLE = 2'b00, // waiting for an issue
    ST_EXEC = 2'b01, // first instruction cycle
    ST_SECOND = 2'b10 // second cycle of call or skip
  } cxd_state_e;

  typedef struct packed {
    cxd_op_e op; // operation
    logic dest; // 0 working register, 1 file
    logic [F_W-1:0] faddr; // file address
    logic [K_W-1:0] k; // call target
  } cxd_instr_s;

  typedef struct packed {
    logic timeout_flag; // set by watchdog clear
    logic power_down_flag; // set by watchdog clear
    logic zero; // result was zero
  } cxd_status_s;

  localparam cxd_instr_s INSTR_RST = '{op: nop_op, dest: 1'b0, faddr: 7'h00, k: 11'h000};
  localparam cxd_status_s STATUS_RST = '{timeout_flag: 1'b1, power_down_flag: 1'b1, zero: 1'b0};

  // next sequential program address
  function automatic logic [PC_W-1:0] pc_inc(input logic [PC_W-1:0] pc);
    return pc + PC_STEP;
  endfunction

endpackage

// ### verilog/cxd_stack.sv
/*
  cxd_stack: hardware return stack, circular, push only.
  assumes: one push per cycle at most; oldest entry is overwritten
  when more than the depth are pushed.
*/
`timescale 1ns/1ps
module cxd_stack (
  input wire logic clk_i, // core clock
  input wire logic nrst_i, // async reset, active low
  input wire logic push_i, // push one return address
  input wire logic [cxd_pkg::PC_W-1:0] data_i, // address to push
  output logic [cxd_pkg::PC_W-1:0] top_o, // current top entry
  output logic [cxd_pkg::SP_W-1:0] sp_o // next free slot
);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [cxd_pkg::PC_W-1:0] mem_q [cxd_pkg::STK_DEPTH]; // stack levels
  logic [cxd_pkg::SP_W-1:0] sp_q; // write pointer
  logic [cxd_pkg::PC_W-1:0] top_q; // copy of newest entry

  // pointer and top copy
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sp_q <= '0;
      top_q <= cxd_pkg::PC_RST;
    end else if (push_i) begin
      sp_q <= sp_q + 3'h1;
      top_q <= data_i;
    end
  end

  // level array, no reset needed
  always_ff @(posedge clk_i) begin
    if (push_i) begin
      mem_q[sp_q] <= data_i;
    end
  end

  assign top_o = top_q;
  assign sp_o = sp_q;

endmodule

// ### verilog/cxd_exec.sv
/*
  cxd_exec: execution unit for watchdog clear, call, complement,
  clear file, clear working register, decrement and decrement-skip,
  with its data file, working register, status, pc and latch,
  all reached over an apb slave.
  assumes: one clock; apb master per amba apb; watchdog counter and
  its prescaler live outside and obey the clear pulse.
*/
// Added by the designer: the APB register port and the register offsets.
// Summary of operation
// RULE1: watchdog clear zeroes counter and prescaler
// RULE2: watchdog clear sets timeout, power down flags
// RULE3: call pushes pc plus one onto stack
// RULE4: call loads 11-bit target into pc low
// RULE5: call loads pc top from latch bits
// RULE6: call takes two cycles, flags untouched
// RULE7: complement writes inverted file, updates zero
// RULE8: destination bit zero selects working register
// RULE9: clear file writes zero, sets zero flag
// RULE10: decrement writes file minus one, zero flag
// RULE11: clear working register zeroes it, sets zero
// RULE12: decrement-skip writes result, flags untouched
// RULE13: zero result discards next fetch, two cycles
// RULE14: nonzero result runs next, single cycle
`timescale 1ns/1ps
module cxd_exec (
  input wire logic clk_i, // core clock, 50 mhz
  input wire logic nrst_i, // async reset, active low
  input wire logic psel_i, // apb select
  input wire logic penable_i, // apb access phase
  input wire logic pwrite_i, // apb write
  input wire logic [cxd_pkg::ADDR_W-1:0] paddr_i, // apb byte address
  input wire logic [cxd_pkg::DATA_W-1:0] pwdata_i, // apb write data
  output logic [cxd_pkg::DATA_W-1:0] prdata_o, // apb read data
  output logic pready_o, // apb ready
  output logic pslverr_o, // apb error, unmapped address
  output logic wdt_clear_o, // clear watchdog counter to zero
  output logic prescaler_clear_o, // clear watchdog prescaler
  output logic flush_o, // discarded fetch marker
  output logic [cxd_pkg::PC_W-1:0] pc_o, // program counter
  output logic [cxd_pkg::PC_W-1:0] stack_top_o // newest return address
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  cxd_pkg::cxd_state_e state_q, state_d; // sequencer
  cxd_pkg::cxd_instr_s instr_q, instr_d; // operation in flight
  cxd_pkg::cxd_status_s status_q, status_d; // flags
  logic [cxd_pkg::BYTE_W-1:0] w_q, w_d; // working register
  logic [cxd_pkg::PC_W-1:0] pc_q, pc_d; // program counter
  logic [cxd_pkg::PCL_W-1:0] pc_high_latch_q, pc_high_latch_d; // pc high latch
  logic skip_q, skip_d; // pending discard of next fetch
  logic wdt_clr_q, wdt_clr_d; // watchdog clear pulse
  logic flush_q, flush_d; // fetch discarded
  logic pready_q; // apb answer
  logic pslverr_q; // apb error answer
  logic [cxd_pkg::DATA_W-1:0] prdata_q, rdata_w; // read data
  logic [cxd_pkg::BYTE_W-1:0] file_q [2**cxd_pkg::F_W]; // data file

  // file write port
  logic fwe; // write enable
  logic [cxd_pkg::F_W-1:0] fwa; // write address
  logic [cxd_pkg::BYTE_W-1:0] fwd; // write data
  logic push_w; // return stack push
  logic [cxd_pkg::SP_W-1:0] sp_w; // stack pointer

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  wire idle_w = (state_q == cxd_pkg::ST_IDLE); // accepts accesses
  wire acc_w = psel_i & penable_i & ~pready_q & idle_w; // access taken
  wire hit_instr = (paddr_i == cxd_pkg::OFF_INSTR); // issue
  wire hit_wreg = (paddr_i == cxd_pkg::OFF_WREG); // working register
  wire hit_status = (paddr_i == cxd_pkg::OFF_STATUS); // flags
  wire hit_pc = (paddr_i == cxd_pkg::OFF_PC); // program counter
  wire hit_pc_high_latch = (paddr_i == cxd_pkg::OFF_PC_HIGH_LATCH); // latch
  wire hit_tos = (paddr_i == cxd_pkg::OFF_TOS); // stack top
  wire hit_state = (paddr_i == cxd_pkg::OFF_STATE); // sequencer
  wire hit_file = (paddr_i >= cxd_pkg::OFF_FILE_LO) &&
                  (paddr_i <= cxd_pkg::OFF_FILE_HI) &&
                  (paddr_i[cxd_pkg::FILE_IDX_LSB-1:0] == '0); // file word
  wire mapped_w = hit_instr | hit_wreg | hit_status | hit_pc | hit_pc_high_latch |
                  hit_tos | hit_state | hit_file; // any register
  wire wr_w = acc_w & pwrite_i & mapped_w; // write takes effect
  wire [cxd_pkg::F_W-1:0] fidx = paddr_i[cxd_pkg::FILE_IDX_LSB +: cxd_pkg::F_W];

  // operation word as written by software
  cxd_pkg::cxd_instr_s new_instr;
  assign new_instr = '{
    op: cxd_pkg::cxd_op_e'(pwdata_i[cxd_pkg::INSTR_OP_LSB +: cxd_pkg::OP_W]),
    dest: pwdata_i[cxd_pkg::INSTR_D_BIT],
    faddr: pwdata_i[cxd_pkg::INSTR_F_LSB +: cxd_pkg::F_W],
    k: pwdata_i[cxd_pkg::INSTR_K_LSB +: cxd_pkg::K_W]};

  // ----------------------------------------------------------------
  // datapath
  // ----------------------------------------------------------------
  wire ex_w = (state_q == cxd_pkg::ST_EXEC); // executing
  wire [cxd_pkg::BYTE_W-1:0] fval = file_q[instr_q.faddr]; // operand
  wire [cxd_pkg::BYTE_W-1:0] comp_w = ~fval; // complement
  wire [cxd_pkg::BYTE_W-1:0] dec_w = fval - cxd_pkg::ONE8; // decrement
  wire [cxd_pkg::BYTE_W-1:0] res_w =
    (instr_q.op == cxd_pkg::complement_file_op) ? comp_w : dec_w; // RULE7
  wire res_zero = (res_w == cxd_pkg::ZERO8); // result is zero
  wire [cxd_pkg::PC_W-1:0] call_pc = {pc_high_latch_q[cxd_pkg::PCL_SEL_LSB +: cxd_pkg::PCL_SEL_W],
                                      instr_q.k}; // RULE4 RULE5

  // ----------------------------------------------------------------
  // sequencer and register next values
  // ----------------------------------------------------------------
  // apb writes only land while idle, execution only while busy, so
  // a hardware flag set never meets a software write in one cycle
  always_comb begin
    state_d = state_q;
    instr_d = instr_q;
    status_d = status_q;
    w_d = w_q;
    pc_d = pc_q;
    pc_high_latch_d = pc_high_latch_q;
    skip_d = skip_q;
    wdt_clr_d = 1'b0;
    flush_d = 1'b0;
    fwe = 1'b0;
    fwa = fidx;
    fwd = pwdata_i[cxd_pkg::BYTE_W-1:0];
    push_w = 1'b0;
    case (state_q)
      cxd_pkg::ST_IDLE: begin
        // software register writes and issue
        if (wr_w && hit_instr) begin
          instr_d = new_instr;
          state_d = cxd_pkg::ST_EXEC;
        end else if (wr_w && hit_wreg) begin
          w_d = pwdata_i[cxd_pkg::BYTE_W-1:0];
        end else if (wr_w && hit_status) begin
          status_d.zero = pwdata_i[cxd_pkg::ST_Z_BIT];
          status_d.power_down_flag = pwdata_i[cxd_pkg::ST_PD_BIT];
          status_d.timeout_flag = pwdata_i[cxd_pkg::ST_TO_BIT];
        end else if (wr_w && hit_pc) begin
          pc_d = pwdata_i[cxd_pkg::PC_W-1:0];
        end else if (wr_w && hit_pc_high_latch) begin
          pc_high_latch_d = pwdata_i[cxd_pkg::PCL_W-1:0];
        end else if (wr_w && hit_file) begin
          fwe = 1'b1;
        end
      end
      cxd_pkg::ST_EXEC: begin
        // first instruction cycle
        pc_d = cxd_pkg::pc_inc(pc_q);
        state_d = cxd_pkg::ST_IDLE;
        case (instr_q.op)
          cxd_pkg::watchdog_clear_op: begin
            wdt_clr_d = 1'b1; // RULE1
            status_d.timeout_flag = 1'b1; // RULE2
            status_d.power_down_flag = 1'b1; // RULE2
          end
          cxd_pkg::call_op: begin
            push_w = 1'b1; // RULE3
            pc_d = call_pc; // RULE4 RULE5
            state_d = cxd_pkg::ST_SECOND; // RULE6
          end
          cxd_pkg::complement_file_op, cxd_pkg::decrement_file_op: begin
            if (instr_q.dest) begin
              fwe = 1'b1; // RULE8
              fwa = instr_q.faddr;
              fwd = res_w;
            end else begin
              w_d = res_w; // RULE8
            end
            status_d.zero = res_zero; // RULE7 RULE10
          end
          cxd_pkg::decrement_skip_zero_op: begin
            if (instr_q.dest) begin
              fwe = 1'b1; // RULE8 RULE12
              fwa = instr_q.faddr;
              fwd = dec_w;
            end else begin
              w_d = dec_w; // RULE8 RULE12
            end
            if (res_zero) begin // RULE13 RULE14
              skip_d = 1'b1; // RULE13
              state_d = cxd_pkg::ST_SECOND; // RULE13
            end
          end
          cxd_pkg::clear_file_op: begin
            fwe = 1'b1; // RULE9
            fwa = instr_q.faddr;
            fwd = cxd_pkg::ZERO8;
            status_d.zero = 1'b1; // RULE9
          end
          cxd_pkg::clear_work_reg_op: begin
            w_d = cxd_pkg::ZERO8; // RULE11
            status_d.zero = 1'b1; // RULE11
          end
          default: begin
            // no operation, pc only
          end
        endcase
      end
      cxd_pkg::ST_SECOND: begin
        // refill cycle; a pending skip steps over the fetched word
        if (skip_q) begin
          pc_d = cxd_pkg::pc_inc(pc_q); // RULE13
        end
        flush_d = skip_q;
        skip_d = 1'b0;
        state_d = cxd_pkg::ST_IDLE;
      end
      default: begin
        state_d = cxd_pkg::ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  always_comb begin
    rdata_w = '0;
    if (hit_instr) begin
      rdata_w[cxd_pkg::INSTR_OP_LSB +: cxd_pkg::OP_W] = instr_q.op;
      rdata_w[cxd_pkg::INSTR_D_BIT] = instr_q.dest;
      rdata_w[cxd_pkg::INSTR_F_LSB +: cxd_pkg::F_W] = instr_q.faddr;
      rdata_w[cxd_pkg::INSTR_K_LSB +: cxd_pkg::K_W] = instr_q.k;
    end else if (hit_wreg) begin
      rdata_w[cxd_pkg::BYTE_W-1:0] = w_q;
    end else if (hit_status) begin
      rdata_w[cxd_pkg::ST_Z_BIT] = status_q.zero;
      rdata_w[cxd_pkg::ST_PD_BIT] = status_q.power_down_flag;
      rdata_w[cxd_pkg::ST_TO_BIT] = status_q.timeout_flag;
    end else if (hit_pc) begin
      rdata_w[cxd_pkg::PC_W-1:0] = pc_q;
    end else if (hit_pc_high_latch) begin
      rdata_w[cxd_pkg::PCL_W-1:0] = pc_high_latch_q;
    end else if (hit_tos) begin
      rdata_w[cxd_pkg::PC_W-1:0] = stack_top_o;
    end else if (hit_state) begin
      rdata_w[cxd_pkg::ST_W-1:0] = state_q;
      rdata_w[cxd_pkg::STATE_SP_LSB +: cxd_pkg::SP_W] = sp_w;
    end else if (hit_file) begin
      rdata_w[cxd_pkg::BYTE_W-1:0] = file_q[fidx];
    end
  end

  // ----------------------------------------------------------------
  // flops
  // ----------------------------------------------------------------
  // control and architectural state
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= cxd_pkg::ST_IDLE;
      instr_q <= cxd_pkg::INSTR_RST;
      status_q <= cxd_pkg::STATUS_RST;
      w_q <= cxd_pkg::ZERO8;
      pc_q <= cxd_pkg::PC_RST;
      pc_high_latch_q <= cxd_pkg::PC_HIGH_LATCH_RST;
      skip_q <= 1'b0;
      wdt_clr_q <= 1'b0;
      flush_q <= 1'b0;
    end else begin
      state_q <= state_d;
      instr_q <= instr_d;
      status_q <= status_d;
      w_q <= w_d;
      pc_q <= pc_d;
      pc_high_latch_q <= pc_high_latch_d;
      skip_q <= skip_d;
      wdt_clr_q <= wdt_clr_d;
      flush_q <= flush_d;
    end
  end

  // apb answer, one wait state per access once the sequencer is idle
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end else begin
      pready_q <= acc_w;
      pslverr_q <= acc_w & ~mapped_w;
      prdata_q <= acc_w ? rdata_w : prdata_q;
    end
  end

  // data file, contents undefined until written
  always_ff @(posedge clk_i) begin
    if (fwe) begin
      file_q[fwa] <= fwd;
    end
  end

  // ----------------------------------------------------------------
  // return stack
  // ----------------------------------------------------------------
  cxd_stack u_stack (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .push_i(push_w), // RULE3
    .data_i(cxd_pkg::pc_inc(pc_q)), // RULE3
    .top_o(stack_top_o),
    .sp_o(sp_w)
  );

  assign prdata_o = prdata_q;
  assign pready_o = pready_q;
  assign pslverr_o = pslverr_q;
  assign wdt_clear_o = wdt_clr_q;
  assign prescaler_clear_o = wdt_clr_q;
  assign flush_o = flush_q;
  assign pc_o = pc_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  wire is_call = ex_w && (instr_q.op == cxd_pkg::call_op);
  wire is_wdt = ex_w && (instr_q.op == cxd_pkg::watchdog_clear_op);
  wire is_dsz = ex_w && (instr_q.op == cxd_pkg::decrement_skip_zero_op);
  wire is_rmw = ex_w && (instr_q.op == cxd_pkg::complement_file_op ||
                         instr_q.op == cxd_pkg::decrement_file_op ||
                         instr_q.op == cxd_pkg::decrement_skip_zero_op);

  sequence call_two_cycles;
    (state_q == cxd_pkg::ST_SECOND) && $stable(status_q) ##1
    (state_q == cxd_pkg::ST_IDLE) && $stable(status_q);
  endsequence

  sequence skip_then_flush;
    (state_q == cxd_pkg::ST_SECOND) ##1
    (state_q == cxd_pkg::ST_IDLE) && flush_o;
  endsequence

  AST_WDT_CLEAR: assert property (is_wdt |=> wdt_clear_o && prescaler_clear_o) // RULE1
    else $error("watchdog clear pulse missing");
  AST_WDT_FLAGS: assert property (is_wdt |=> status_q.timeout_flag &&
    status_q.power_down_flag && $stable(status_q.zero)) // RULE2
    else $error("watchdog clear flags wrong");
  AST_CALL_PUSH: assert property (is_call |=>
    stack_top_o == cxd_pkg::pc_inc($past(pc_q))) // RULE3
    else $error("call return address wrong");
  AST_CALL_LOW: assert property (is_call |=>
    pc_o[cxd_pkg::K_W-1:0] == $past(instr_q.k)) // RULE4
    else $error("call target low bits wrong");
  AST_CALL_HIGH: assert property (is_call |=>
    pc_o[cxd_pkg::PC_W-1:cxd_pkg::K_W] ==
    $past(pc_high_latch_q[cxd_pkg::PCL_SEL_LSB +: cxd_pkg::PCL_SEL_W])) // RULE5
    else $error("call target high bits wrong");
  AST_CALL_TWO: assert property (is_call |-> ##1 call_two_cycles) // RULE6
    else $error("call timing or flags wrong");
  AST_COMPLEMENT_FILE_OP: assert property (ex_w && instr_q.op == cxd_pkg::complement_file_op &&
    !instr_q.dest |=> w_q == ~$past(fval) && status_q.zero == (w_q == cxd_pkg::ZERO8)) // RULE7
    else $error("complement result wrong");
  AST_DEST_FILE: assert property (is_rmw && instr_q.dest |=>
    $stable(w_q) && file_q[$past(instr_q.faddr)] == $past(res_w)) // RULE8
    else $error("file destination wrong");
  AST_CLEAR_FILE_OP: assert property (ex_w && instr_q.op == cxd_pkg::clear_file_op |=>
    file_q[$past(instr_q.faddr)] == cxd_pkg::ZERO8 && status_q.zero) // RULE9
    else $error("clear file wrong");
  AST_DECREMENT_FILE_OP: assert property (ex_w && instr_q.op == cxd_pkg::decrement_file_op |=>
    status_q.zero == ($past(fval) == cxd_pkg::ONE8) &&
    $stable(status_q.timeout_flag) && $stable(status_q.power_down_flag)) // RULE10
    else $error("decrement flags wrong");
  AST_CLEAR_WORK_REG_OP: assert property (ex_w && instr_q.op == cxd_pkg::clear_work_reg_op |=>
    w_q == cxd_pkg::ZERO8 && status_q.zero) // RULE11
    else $error("clear working register wrong");
  AST_DSZ_FLAGS: assert property (is_dsz |=> $stable(status_q)) // RULE12
    else $error("decrement skip touched flags");
  AST_DSZ_SKIP: assert property (is_dsz && fval == cxd_pkg::ONE8 |=>
    skip_then_flush) // RULE13
    else $error("skip not taken");
  AST_DSZ_RUN: assert property (is_dsz && fval != cxd_pkg::ONE8 |=>
    state_q == cxd_pkg::ST_IDLE && pc_o == cxd_pkg::pc_inc($past(pc_q))) // RULE14
    else $error("nonzero decrement skip not single cycle");

endmodule

// ### verif/cxd_apb_host.sv
/*
  cxd_apb_host: apb master model facing the execution unit.
  assumes: caller enters xfer from procedural code; one transfer at a time.
*/
`timescale 1ns/1ps
module cxd_apb_host (
  input wire logic clk_i, // core clock
  input wire logic [31:0] prdata_i, // read data
  input wire logic pready_i, // slave ready
  input wire logic pslverr_i, // slave error
  output logic psel_o, // select
  output logic penable_o, // access phase
  output logic pwrite_o, // direction
  output logic [11:0] paddr_o, // byte address
  output logic [31:0] pwdata_o // write data
);
  // idle bus from time zero
  initial begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = 12'h000;
    pwdata_o = 32'h0;
  end
  // setup, access, hold until ready seen at an edge, then release
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge clk_i);
    psel_o <= 1'b1;
    pwrite_o <= w;
    paddr_o <= a;
    pwdata_o <= d;
    @(posedge clk_i);
    penable_o <= 1'b1;
    // no cycle limit here: only the bench watchdog ends a stuck wait
    do begin
      @(posedge clk_i);
    end while (pready_i !== 1'b1);
    r = prdata_i;
    e = pslverr_i;
    psel_o <= 1'b0;
    penable_o <= 1'b0;
  endtask
endmodule

// ### verif/testbench.sv
/*
  testbench: issues each operation except nop over apb and checks registers and pins.
  assumes: cxd_exec register map and opcodes as in the package.
*/
`timescale 1ns/1ps
module testbench;
  logic clk_i, nrst_i, psel, penable, pwrite, pready, pslverr, wclr, pclr, flush;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [12:0] pc, stack_top, epc, etos;
  int fail_count = 0, checks = 0, nwclr = 0, npclr = 0, nflush = 0;
  cxd_exec cxd_exec_i (.clk_i(clk_i), .nrst_i(nrst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .wdt_clear_o(wclr), .prescaler_clear_o(pclr),
    .flush_o(flush), .pc_o(pc), .stack_top_o(stack_top));
  cxd_apb_host cxd_apb_host_i (.clk_i(clk_i), .prdata_i(prdata), .pready_i(pready),
    .pslverr_i(pslverr), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
    .paddr_o(paddr), .pwdata_o(pwdata));
  // pulse counters
  always @(posedge clk_i) begin
    if (wclr === 1'b1) nwclr++;
    if (pclr === 1'b1) npclr++;
    if (flush === 1'b1) nflush++;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", n, e, g);
      fail_count++;
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    cxd_apb_host_i.xfer(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input string n);
    logic [31:0] r;
    logic er;
    cxd_apb_host_i.xfer(1'b0, a, 32'h0, r, er);
    chk(n, e, r);
  endtask
  function automatic logic [11:0] fa(input logic [6:0] f);
    return 12'h200 + {3'h0, f, 2'b00};
  endfunction
  // issue one operation; pc advances by one unless overridden
  task automatic issue(input logic [3:0] op, input logic d, input logic [6:0] f,
                       input logic [10:0] k);
    wr(12'h000, {5'h0, k, 4'h0, f, d, op});
    epc = epc + 13'h1;
  endtask
  task automatic t_wdt;
    wr(12'h008, 32'h04);
    issue(cxd_pkg::watchdog_clear_op, 1'b0, 7'h0, 11'h0);
    rd(12'h008, 32'h1c, "status");
    chk("wdt_clear", 32'd1, nwclr);
    chk("presc_clear", 32'd1, npclr);
  endtask
  task automatic t_call;
    wr(12'h010, 32'h08);
    etos = epc + 13'h1;
    issue(cxd_pkg::call_op, 1'b0, 7'h0, 11'h555);
    epc = 13'h0d55;
    rd(12'h00c, {19'h0, epc}, "pc");
    chk("pc_o", {19'h0, epc}, {19'h0, pc});
    chk("stack_top", {19'h0, etos}, {19'h0, stack_top});
    rd(12'h008, 32'h1c, "status");
  endtask
  task automatic t_complement_file_op;
    wr(fa(7'd5), 32'h5a);
    issue(cxd_pkg::complement_file_op, 1'b1, 7'd5, 11'h0);
    rd(fa(7'd5), 32'ha5, "file5");
    rd(12'h008, 32'h18, "status");
    issue(cxd_pkg::complement_file_op, 1'b0, 7'd5, 11'h0);
    rd(12'h004, 32'h5a, "w");
    rd(fa(7'd5), 32'ha5, "file5");
  endtask
  task automatic t_clear_file_op_dec;
    wr(fa(7'd127), 32'h33);
    issue(cxd_pkg::clear_file_op, 1'b0, 7'd127, 11'h0);
    rd(fa(7'd127), 32'h0, "file127");
    rd(12'h008, 32'h1c, "status");
    wr(fa(7'd3), 32'h00);
    issue(cxd_pkg::decrement_file_op, 1'b1, 7'd3, 11'h0);
    rd(fa(7'd3), 32'hff, "file3");
    rd(12'h008, 32'h18, "status");
    issue(cxd_pkg::decrement_file_op, 1'b0, 7'd127, 11'h0);
    rd(12'h004, 32'hff, "w");
  endtask
  task automatic t_clear_work_reg_op;
    issue(cxd_pkg::clear_work_reg_op, 1'b0, 7'h0, 11'h0);
    rd(12'h004, 32'h0, "w");
    rd(12'h008, 32'h1c, "status");
  endtask
  task automatic t_skip;
    wr(12'h008, 32'h00);
    wr(fa(7'd9), 32'h02);
    issue(cxd_pkg::decrement_skip_zero_op, 1'b1, 7'd9, 11'h0);
    rd(fa(7'd9), 32'h01, "file9");
    rd(12'h00c, {19'h0, epc}, "pc");
    chk("flush", 32'd0, nflush);
    issue(cxd_pkg::decrement_skip_zero_op, 1'b0, 7'd9, 11'h0);
    epc = epc + 13'h1;
    rd(12'h004, 32'h0, "w");
    rd(12'h00c, {19'h0, epc}, "pc");
    chk("pc_o", {19'h0, epc}, {19'h0, pc});
    chk("flush", 32'd1, nflush);
    rd(12'h008, 32'h00, "status");
  endtask
  task automatic t_err;
    logic [31:0] r;
    logic e;
    cxd_apb_host_i.xfer(1'b0, 12'h100, 32'h0, r, e);
    chk("slverr", 32'd1, {31'h0, e});
    chk("rdata", 32'h0, r);
  endtask
  task automatic report_and_stop;
    if (fail_count == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  initial begin
    nrst_i = 1'b0;
    epc = 13'h0;
    repeat (3) @(posedge clk_i);
    nrst_i <= 1'b1;
    rd(12'h008, 32'h18, "status_rst");
    chk("pc_rst", 32'h0, {19'h0, pc});
    chk("tos_rst", 32'h0, {19'h0, stack_top});
    t_wdt;
    t_call;
    t_complement_file_op;
    t_clear_file_op_dec;
    t_clear_work_reg_op;
    t_skip;
    t_err;
    report_and_stop;
  end
  initial begin
    #100000;
    fail_count++;
    report_and_stop;
  end
endmodule
